/* File: drp_map.vh */
// Register map, field positions and timing counts of the descriptor ring poller
//------------------------------------------------------------
// Contract
// - Entry is 16 bytes in 32-bit structure mode, else 8 bytes.
// - Init-loaded lengths capped 128/512; direct length writes allow up to 65535.
// - Init request loads both ring bases and entry counts internally.
// - Last init step: current pointer gets base, next pointer gets following entry.
// - Ownership flag 1 means the device owns descriptor and buffer.
// - Only the owner writes fields or hands over; others may only read.
// - Poll periodically only while channel and frame processing are idle.
// - Transmit poll disable bit suppresses all transmit descriptor polling.
// - Poll reads rx word 1 then 0, later tx word 1 then 0, separate tenures.
// - Polled words go to shadow registers; unowned descriptor status is ignored.
// - Receive poll needs receiver on, time elapsed, current or next rx unowned.
// - Receiver off means no receive descriptor access for polling.
// - Receive length zero means one entry and no next-entry check.
// - Transmit poll needs tx unowned, polling enabled, transmitter on; timer or frame.
// - Transmit demand leaves interval counting and polls at once.
// - Demanded poll checks receive entries first unless already owned.
// - Demand outside interval counting waits until counting resumes.
// - Poll interval defaults to 65,536 clocks, replaceable by the interval register.
// - Sequencer runs at half the system clock rate.
// - Unowned transmit entry: resume counting, recheck same entry next expiry.
//------------------------------------------------------------
`ifndef DRP_MAP_VH
`define DRP_MAP_VH

// Word offsets on the register bus (byte addresses)
`define DRP_OFS_MAIN 8'h00
`define DRP_OFS_FEATURE 8'h04
`define DRP_OFS_IMASK 8'h08
`define DRP_OFS_STRUCT 8'h0C
`define DRP_OFS_INIT_RX_BASE 8'h10
`define DRP_OFS_INIT_TX_BASE 8'h14
`define DRP_OFS_INIT_LENS 8'h18
`define DRP_OFS_RX_LEN 8'h1C
`define DRP_OFS_TX_LEN 8'h20
`define DRP_OFS_POLL_IVAL 8'h24
`define DRP_OFS_CUR_RX 8'h28
`define DRP_OFS_CUR_TX 8'h2C
`define DRP_OFS_NEXT_RX 8'h30
`define DRP_OFS_NEXT_TX 8'h34
`define DRP_OFS_RX_STAT 8'h38
`define DRP_OFS_RX_ADDRW 8'h3C
`define DRP_OFS_TX_STAT 8'h40
`define DRP_OFS_TX_ADDRW 8'h44
`define DRP_OFS_OWN 8'h48

// Field positions
`define DRP_MAIN_INIT 0
`define DRP_MAIN_RUN 1
`define DRP_MAIN_STOP 2
`define DRP_MAIN_DEMAND 3
`define DRP_MAIN_TRANSMITTER_ON_FLAG 4
`define DRP_MAIN_RECEIVER_ON_FLAG 5
`define DRP_MAIN_IDONE 8
`define DRP_MAIN_BUSY 9
`define DRP_FEAT_TXPOLLDIS 2
`define DRP_IMASK_LOOKAHEAD 5
`define DRP_STRUCT_WIDTH32 8
`define DRP_OWN_BIT32 31
`define DRP_OWN_BIT16 15

// Sizes and counts
`define DRP_ENTRY_SHIFT32 4
`define DRP_ENTRY_SHIFT16 3
`define DRP_INIT_MAX16 16'h0080
`define DRP_INIT_MAX32 16'h0200
`define DRP_POLL_DEFAULT 17'h10000

`endif

/* File: drp_poller.v */
// Descriptor ring poller: ring pointers, ownership polling and register slave
`timescale 1ns/1ps
`include "drp_map.vh"

module drp_poller #(
	parameter [16:0] POLL_DEFAULT = `DRP_POLL_DEFAULT
) (
	input wire clock,
	input wire rst_b,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire chanBusy,
	input wire frameRxDone,
	input wire frameTxDone,
	input wire rxAdvance,
	input wire txAdvance,
	output reg memReq,
	output wire memLock,
	output reg [31:0] memAddr,
	input wire memAck,
	input wire [31:0] memRdData,
	output wire pollBusy,
	output wire rxOwned,
	output wire txOwned
);

	//------------------------------------------------------------
	// Sequencer states
	//------------------------------------------------------------
	localparam [3:0] ST_STOP = 4'h0;
	localparam [3:0] ST_INIT = 4'h1;
	localparam [3:0] ST_COUNT = 4'h2;
	localparam [3:0] ST_RX1 = 4'h3;
	localparam [3:0] ST_RX0 = 4'h4;
	localparam [3:0] ST_RXN = 4'h5;
	localparam [3:0] ST_GAP = 4'h6;
	localparam [3:0] ST_TX1 = 4'h7;
	localparam [3:0] ST_TX0 = 4'h8;

	//------------------------------------------------------------
	// Functions
	//------------------------------------------------------------
	// Entry address from ring base and index
	function [31:0] entryAddr;
		input [31:0] base;
		input [15:0] idx;
		input wide;
		begin
			if (wide) begin
				entryAddr = base + ({16'h0000, idx} << `DRP_ENTRY_SHIFT32);
			end else begin
				entryAddr = base + ({16'h0000, idx} << `DRP_ENTRY_SHIFT16);
			end
		end
	endfunction

	// Following index with wrap; length zero acts as one entry
	function [15:0] nextIdx;
		input [15:0] idx;
		input [15:0] len;
		reg [16:0] inc;
		begin
			inc = {1'b0, idx} + 17'h00001;
			if (inc >= {1'b0, len}) begin
				nextIdx = 16'h0000;
			end else begin
				nextIdx = inc[15:0];
			end
		end
	endfunction

	// Byte-lane merge for register writes
	function [31:0] laneMerge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] sel;
		integer i;
		begin
			laneMerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					laneMerge[i*8 +: 8] = data[i*8 +: 8];
				end
			end
		end
	endfunction

	// Clamp a ring length taken from the init source
	function [15:0] initClamp;
		input [15:0] len;
		input wide;
		reg [15:0] lim;
		begin
			lim = wide ? `DRP_INIT_MAX32 : `DRP_INIT_MAX16;
			initClamp = (len > lim) ? lim : len;
		end
	endfunction

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	reg [3:0] state_q;
	reg phase_q;
	reg initPend_q, runPend_q, stopPend_q, demand_q, frameEv_q;
	reg transmitter_on_flag_q, receiver_on_flag_q, initDone_q, txPollDis_q, lookahead_q, wide_q;
	reg [31:0] initRxBase_q, initTxBase_q, initLens_q;
	reg [31:0] rxBase_q, txBase_q;
	reg [15:0] rxLen_q, txLen_q, rxIdx_q, txIdx_q;
	reg [31:0] curRx_q, curTx_q, nextRx_q, nextTx_q;
	reg [31:0] rxStat_q, rxAddrW_q, txStat_q, txAddrW_q;
	reg curRxOwn_q, nextRxOwn_q, curTxOwn_q, txPlan_q;
	reg [16:0] pollIval_q, pollCnt_q;
	reg memDone_q;
	reg [31:0] memData_q;
	reg [31:0] rdMux;
	wire tick, wbReq, wbWr, rxSingle, expired, rxNeed, txNeed, dataOwn, pollGo;
	wire [31:0] wordStep;
	wire [31:0] rxLenWr, txLenWr, ivalWr;
	wire [17:0] cntInc;

	assign tick = phase_q;
	assign wbReq = wb_cyc_i & wb_stb_i;
	assign wbWr = wbReq & wb_we_i & wb_ack_o;
	assign rxSingle = (rxLen_q <= 16'h0001);
	assign cntInc = {1'b0, pollCnt_q} + 18'h00001;
	assign expired = (cntInc >= {1'b0, pollIval_q});
	assign rxNeed = receiver_on_flag_q & (~curRxOwn_q | (~rxSingle & ~nextRxOwn_q));
	assign txNeed = transmitter_on_flag_q & ~txPollDis_q & ~curTxOwn_q;
	assign dataOwn = wide_q ? memData_q[`DRP_OWN_BIT32] : memData_q[`DRP_OWN_BIT16];
	// only when channel idle; demand starts at once
	assign pollGo = tick & (state_q == ST_COUNT) & ~chanBusy & (expired | demand_q | frameEv_q);
	assign wordStep = wide_q ? 32'h00000004 : 32'h00000002;
	// lock spans one ring's reads only
	assign memLock = (state_q == ST_RX1) | (state_q == ST_RX0) | (state_q == ST_RXN) |
		(state_q == ST_TX1) | (state_q == ST_TX0);
	assign pollBusy = memLock | (state_q == ST_GAP);
	assign rxOwned = curRxOwn_q;
	assign txOwned = curTxOwn_q;
	// Lane-merged write values, cut to register width where they land
	assign rxLenWr = laneMerge({16'h0000, rxLen_q}, wb_dat_i, wb_sel_i);
	assign txLenWr = laneMerge({16'h0000, txLen_q}, wb_dat_i, wb_sel_i);
	assign ivalWr = laneMerge({15'h0000, pollIval_q}, wb_dat_i, wb_sel_i);

	//------------------------------------------------------------
	// Bus slave answer
	//------------------------------------------------------------
	// Read mux; unmapped words read zero
	always @* begin
		rdMux = 32'h00000000;
		case (wb_adr_i & 8'hFC)
			`DRP_OFS_MAIN: begin
				rdMux[`DRP_MAIN_DEMAND] = demand_q;
				rdMux[`DRP_MAIN_TRANSMITTER_ON_FLAG] = transmitter_on_flag_q;
				rdMux[`DRP_MAIN_RECEIVER_ON_FLAG] = receiver_on_flag_q;
				rdMux[`DRP_MAIN_IDONE] = initDone_q;
				rdMux[`DRP_MAIN_BUSY] = pollBusy;
			end
			`DRP_OFS_FEATURE: rdMux[`DRP_FEAT_TXPOLLDIS] = txPollDis_q;
			`DRP_OFS_IMASK: rdMux[`DRP_IMASK_LOOKAHEAD] = lookahead_q;
			`DRP_OFS_STRUCT: rdMux[`DRP_STRUCT_WIDTH32] = wide_q;
			`DRP_OFS_INIT_RX_BASE: rdMux = initRxBase_q;
			`DRP_OFS_INIT_TX_BASE: rdMux = initTxBase_q;
			`DRP_OFS_INIT_LENS: rdMux = initLens_q;
			`DRP_OFS_RX_LEN: rdMux = {16'h0000, rxLen_q};
			`DRP_OFS_TX_LEN: rdMux = {16'h0000, txLen_q};
			`DRP_OFS_POLL_IVAL: rdMux = {15'h0000, pollIval_q};
			`DRP_OFS_CUR_RX: rdMux = curRx_q;
			`DRP_OFS_CUR_TX: rdMux = curTx_q;
			`DRP_OFS_NEXT_RX: rdMux = nextRx_q;
			`DRP_OFS_NEXT_TX: rdMux = nextTx_q;
			`DRP_OFS_RX_STAT: rdMux = rxStat_q;
			`DRP_OFS_RX_ADDRW: rdMux = rxAddrW_q;
			`DRP_OFS_TX_STAT: rdMux = txStat_q;
			`DRP_OFS_TX_ADDRW: rdMux = txAddrW_q;
			`DRP_OFS_OWN: rdMux = {29'h00000000, curTxOwn_q, nextRxOwn_q, curRxOwn_q};
			default: rdMux = 32'h00000000;
		endcase
	end

	// Ack one cycle after request, dropped the next cycle
	always @(posedge clock) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbReq & ~wb_ack_o;
			if (wbReq & ~wb_ack_o) begin
				wb_dat_o <= rdMux;
			end
		end
	end

	//------------------------------------------------------------
	// Registers, sequencer and memory port
	//------------------------------------------------------------
	// One process so every shared register has one driver
	always @(posedge clock) begin
		if (!rst_b) begin
			state_q <= ST_STOP;
			phase_q <= 1'b0;
			initPend_q <= 1'b0;
			runPend_q <= 1'b0;
			stopPend_q <= 1'b0;
			demand_q <= 1'b0;
			frameEv_q <= 1'b0;
			transmitter_on_flag_q <= 1'b0;
			receiver_on_flag_q <= 1'b0;
			initDone_q <= 1'b0;
			txPollDis_q <= 1'b0;
			lookahead_q <= 1'b0;
			wide_q <= 1'b0;
			initRxBase_q <= 32'h00000000;
			initTxBase_q <= 32'h00000000;
			initLens_q <= 32'h00000000;
			rxBase_q <= 32'h00000000;
			txBase_q <= 32'h00000000;
			rxLen_q <= 16'h0000;
			txLen_q <= 16'h0000;
			rxIdx_q <= 16'h0000;
			txIdx_q <= 16'h0000;
			curRx_q <= 32'h00000000;
			curTx_q <= 32'h00000000;
			nextRx_q <= 32'h00000000;
			nextTx_q <= 32'h00000000;
			rxStat_q <= 32'h00000000;
			rxAddrW_q <= 32'h00000000;
			txStat_q <= 32'h00000000;
			txAddrW_q <= 32'h00000000;
			curRxOwn_q <= 1'b0;
			nextRxOwn_q <= 1'b0;
			curTxOwn_q <= 1'b0;
			txPlan_q <= 1'b0;
			pollIval_q <= POLL_DEFAULT;
			pollCnt_q <= 17'h00000;
			memReq <= 1'b0;
			memAddr <= 32'h00000000;
			memDone_q <= 1'b0;
			memData_q <= 32'h00000000;
		end else begin
			phase_q <= ~phase_q;

			// Pending events; set wins over consumption below
			if (frameRxDone | frameTxDone) begin
				frameEv_q <= 1'b1;
			end

			// Memory read handshake runs at full rate
			if (memReq & memAck) begin
				memReq <= 1'b0;
				memDone_q <= 1'b1;
				memData_q <= memRdData;
			end

			// Frame logic moves the rings on
			if (rxAdvance) begin
				rxIdx_q <= nextIdx(rxIdx_q, rxLen_q);
				curRx_q <= nextRx_q;
				nextRx_q <= entryAddr(rxBase_q, nextIdx(nextIdx(rxIdx_q, rxLen_q), rxLen_q),
					wide_q);
				curRxOwn_q <= nextRxOwn_q;
				nextRxOwn_q <= 1'b0;
			end
			if (txAdvance) begin
				txIdx_q <= nextIdx(txIdx_q, txLen_q);
				curTx_q <= nextTx_q;
				nextTx_q <= entryAddr(txBase_q, nextIdx(nextIdx(txIdx_q, txLen_q), txLen_q),
					wide_q);
				curTxOwn_q <= 1'b0;
			end

			// Interval counter runs while counting, saturates at expiry
			if (state_q == ST_COUNT && !expired) begin
				pollCnt_q <= cntInc[16:0];
			end

			// Sequencer steps on the half-rate tick
			if (tick) begin
				case (state_q)
					ST_STOP: begin
						if (initPend_q) begin
							initPend_q <= 1'b0;
							state_q <= ST_INIT;
						end else if (runPend_q) begin
							runPend_q <= 1'b0;
							transmitter_on_flag_q <= 1'b1;
							receiver_on_flag_q <= 1'b1;
							rxIdx_q <= 16'h0000;
							txIdx_q <= 16'h0000;
							curRx_q <= rxBase_q;
							curTx_q <= txBase_q;
							nextRx_q <= entryAddr(rxBase_q, nextIdx(16'h0000, rxLen_q), wide_q);
							nextTx_q <= entryAddr(txBase_q, nextIdx(16'h0000, txLen_q), wide_q);
							curRxOwn_q <= 1'b0;
							nextRxOwn_q <= 1'b0;
							curTxOwn_q <= 1'b0;
							pollCnt_q <= 17'h00000;
							state_q <= ST_COUNT;
						end
					end
					ST_INIT: begin
						rxBase_q <= initRxBase_q;
						txBase_q <= initTxBase_q;
						rxLen_q <= initClamp(initLens_q[15:0], wide_q);
						txLen_q <= initClamp(initLens_q[31:16], wide_q);
						// current gets base, next gets following entry
						rxIdx_q <= 16'h0000;
						txIdx_q <= 16'h0000;
						curRx_q <= initRxBase_q;
						curTx_q <= initTxBase_q;
						nextRx_q <= entryAddr(initRxBase_q,
							nextIdx(16'h0000, initClamp(initLens_q[15:0], wide_q)), wide_q);
						nextTx_q <= entryAddr(initTxBase_q,
							nextIdx(16'h0000, initClamp(initLens_q[31:16], wide_q)), wide_q);
						curRxOwn_q <= 1'b0;
						nextRxOwn_q <= 1'b0;
						curTxOwn_q <= 1'b0;
						// default restored; write follows init done
						pollIval_q <= POLL_DEFAULT;
						initDone_q <= 1'b1;
						state_q <= ST_STOP;
					end
					ST_COUNT: begin
						if (initPend_q | stopPend_q) begin
							state_q <= ST_STOP;
						end else if (pollGo) begin
							// demand consumed only here; holds otherwise
							demand_q <= 1'b0;
							frameEv_q <= frameRxDone | frameTxDone;
							txPlan_q <= txNeed;
							// receive first; rxNeed needs receiver on
							if (rxNeed && (expired || demand_q)) begin
								state_q <= ST_RX1;
							end else if (txNeed) begin
								state_q <= ST_TX1;
							end else begin
								pollCnt_q <= 17'h00000;
							end
						end
					end
					ST_RX1: begin
						if (memDone_q) begin
							memDone_q <= 1'b0;
							curRxOwn_q <= dataOwn;
							if (dataOwn) begin
								rxStat_q <= memData_q;
							end
							state_q <= ST_RX0;
						end
					end
					ST_RX0: begin
						if (memDone_q) begin
							memDone_q <= 1'b0;
							if (curRxOwn_q) begin
								rxAddrW_q <= memData_q;
							end
							// no next check on a single entry ring
							if (curRxOwn_q && !rxSingle) begin
								state_q <= ST_RXN;
							end else begin
								state_q <= ST_GAP;
							end
						end
					end
					ST_RXN: begin
						if (memDone_q) begin
							memDone_q <= 1'b0;
							nextRxOwn_q <= dataOwn;
							state_q <= ST_GAP;
						end
					end
					ST_GAP: begin
						if (txPlan_q && txNeed) begin
							state_q <= ST_TX1;
						end else begin
							pollCnt_q <= 17'h00000;
							state_q <= ST_COUNT;
						end
					end
					ST_TX1: begin
						if (memDone_q) begin
							memDone_q <= 1'b0;
							curTxOwn_q <= dataOwn;
							if (dataOwn) begin
								txStat_q <= memData_q;
							end
							state_q <= ST_TX0;
						end
					end
					ST_TX0: begin
						if (memDone_q) begin
							memDone_q <= 1'b0;
							if (curTxOwn_q) begin
								txAddrW_q <= memData_q;
							end
							// same entry rechecked at next expiry; restart
							pollCnt_q <= 17'h00000;
							state_q <= ST_COUNT;
						end
					end
					default: state_q <= ST_STOP;
				endcase
			end

			// Issue the read for the word the state needs
			// reads only; descriptors are never written back
			if (!memReq && !memDone_q) begin
				case (state_q)
					ST_RX1: begin
						memReq <= 1'b1;
						memAddr <= curRx_q + wordStep;
					end
					ST_RX0: begin
						memReq <= 1'b1;
						memAddr <= curRx_q;
					end
					ST_RXN: begin
						memReq <= 1'b1;
						memAddr <= nextRx_q + wordStep;
					end
					ST_TX1: begin
						memReq <= 1'b1;
						memAddr <= curTx_q + wordStep;
					end
					ST_TX0: begin
						memReq <= 1'b1;
						memAddr <= curTx_q;
					end
					default: memReq <= 1'b0;
				endcase
			end

			// Stop takes effect in idle states only
			if (tick && stopPend_q && (state_q == ST_STOP || state_q == ST_COUNT)) begin
				stopPend_q <= 1'b0;
				transmitter_on_flag_q <= 1'b0;
				receiver_on_flag_q <= 1'b0;
				state_q <= ST_STOP;
			end

			// Register writes at the acknowledged edge; a write wins over any sequencer update in the same cycle
			if (wbWr) begin
				case (wb_adr_i & 8'hFC)
					`DRP_OFS_MAIN: begin
						if (wb_sel_i[0]) begin
							if (wb_dat_i[`DRP_MAIN_INIT]) begin
								initPend_q <= 1'b1;
								initDone_q <= 1'b0;
							end
							if (wb_dat_i[`DRP_MAIN_RUN]) begin
								runPend_q <= 1'b1;
							end
							if (wb_dat_i[`DRP_MAIN_STOP]) begin
								stopPend_q <= 1'b1;
							end
							if (wb_dat_i[`DRP_MAIN_DEMAND]) begin
								demand_q <= 1'b1;
							end
						end
					end
					`DRP_OFS_FEATURE: begin
						if (wb_sel_i[0]) begin
							txPollDis_q <= wb_dat_i[`DRP_FEAT_TXPOLLDIS];
						end
					end
					`DRP_OFS_IMASK: begin
						if (wb_sel_i[0]) begin
							lookahead_q <= wb_dat_i[`DRP_IMASK_LOOKAHEAD];
						end
					end
					`DRP_OFS_STRUCT: begin
						if (wb_sel_i[1]) begin
							wide_q <= wb_dat_i[`DRP_STRUCT_WIDTH32];
						end
					end
					`DRP_OFS_INIT_RX_BASE: initRxBase_q <= laneMerge(initRxBase_q, wb_dat_i, wb_sel_i);
					`DRP_OFS_INIT_TX_BASE: initTxBase_q <= laneMerge(initTxBase_q, wb_dat_i, wb_sel_i);
					`DRP_OFS_INIT_LENS: initLens_q <= laneMerge(initLens_q, wb_dat_i, wb_sel_i);
					// direct lengths take the full 16 bits
					`DRP_OFS_RX_LEN: rxLen_q <= rxLenWr[15:0];
					`DRP_OFS_TX_LEN: txLen_q <= txLenWr[15:0];
					`DRP_OFS_POLL_IVAL: pollIval_q <= ivalWr[16:0];
					default: begin
					end
				endcase
			end
		end
	end

endmodule // drp_poller

/* File: drp_poller_sva.sv */
// Port assertions for the descriptor ring poller
`timescale 1ns/1ps

module drp_poller_sva #(
	parameter [16:0] POLL_DEFAULT = 17'h10000
) (
	input wire clock,
	input wire rst_b,
	input wire chanBusy,
	input wire memReq,
	input wire memLock,
	input wire [31:0] memAddr,
	input wire memAck,
	input wire pollBusy,
	input wire rxOwned,
	input wire txOwned
);

	// ------------------------------------------------------------
	// Memory port and ownership relations
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_req_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("memory request moved before its answer");
	property p_req_drop; memReq && memAck |=> !memReq; endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("memory request held after its answer");
	property p_lock_cover; memReq |-> memLock; endproperty
	a_lock_cover: assert property (p_lock_cover)
		else $error("memory read outside a bus tenure");
	property p_lock_idle; $fell(memLock) && pollBusy |=> !memLock; endproperty
	a_lock_idle: assert property (p_lock_idle)
		else $error("receive and transmit tenures not separated");
	property p_busy_cover; memReq |-> pollBusy; endproperty
	a_busy_cover: assert property (p_busy_cover)
		else $error("descriptor read outside a poll");
	property p_idle_start; $rose(pollBusy) |-> !$past(chanBusy); endproperty
	a_idle_start: assert property (p_idle_start)
		else $error("poll started during channel activity");
	property p_rx_own_src; $rose(rxOwned) |-> $past(pollBusy); endproperty
	a_rx_own_src: assert property (p_rx_own_src)
		else $error("receive ownership taken without a poll");
	property p_tx_own_src; $rose(txOwned) |-> $past(pollBusy); endproperty
	a_tx_own_src: assert property (p_tx_own_src)
		else $error("transmit ownership taken without a poll");

endmodule // drp_poller_sva

bind drp_poller drp_poller_sva #(.POLL_DEFAULT(POLL_DEFAULT)) i_sva (.clock(clock), .rst_b(rst_b),
	.chanBusy(chanBusy), .memReq(memReq), .memLock(memLock), .memAddr(memAddr), .memAck(memAck),
	.pollBusy(pollBusy), .rxOwned(rxOwned), .txOwned(txOwned));

/* File: drp_mem_model.sv */
// Host memory model answering descriptor reads
`timescale 1ns/1ps

module drp_mem_model (
	input wire clock,
	input wire rst_b,
	input wire memReq,
	input wire [31:0] memAddr,
	input wire slow,
	output logic memAck,
	output logic [31:0] memRdData
);

	// software layout: aligned entries, owner flag preset
	logic [31:0] mem [bit [31:0]];
	logic [31:0] seen[$];
	int waitCnt;

	task automatic put(input logic [31:0] a, input logic [31:0] d);
		mem[a] = d;
	endtask

	// read-only answers; idle data toggles so stale values never match
	always @(posedge clock) begin
		if (!rst_b) begin
			memAck <= 1'b0;
			memRdData <= 32'h00000000;
			waitCnt <= 0;
		end else if (memReq && !memAck && waitCnt >= (slow ? 3 : 0)) begin
			memAck <= 1'b1;
			memRdData <= mem.exists(memAddr) ? mem[memAddr] : 32'h00000000;
			seen.push_back(memAddr);
			waitCnt <= 0;
		end else begin
			memAck <= 1'b0;
			memRdData <= ~memRdData;
			waitCnt <= (memReq && !memAck) ? waitCnt + 1 : 0;
		end
	end

endmodule // drp_mem_model

/* File: tb.sv */
// Self-checking testbench for the descriptor ring poller
`timescale 1ns/1ps
`include "drp_map.vh"

module tb;

	logic clock, rst_b, cyc, stb, we, chanBusy, frameRxDone, frameTxDone, rxAdvance, txAdvance;
	logic slow;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rd;
	wire [31:0] rdat, memAddr, memRdData;
	wire ack, memReq, memLock, memAck, pollBusy, rxOwned, txOwned;
	int error_cnt = 0;
	int checked = 0;
	int n;
	logic [31:0] exp[$];
	localparam int IVAL = 64;

	drp_poller #(.POLL_DEFAULT(17'h00020)) i_dut (.clock, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .chanBusy, .frameRxDone, .frameTxDone, .rxAdvance, .txAdvance, .memReq,
		.memLock, .memAddr, .memAck, .memRdData, .pollBusy, .rxOwned, .txOwned);
	drp_mem_model i_mem (.clock, .rst_b, .memReq, .memAddr, .slow, .memAck, .memRdData);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	// Classic cycle; no fixed latency assumed, the watchdog bounds a hang
	task automatic wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cmp({31'h0, ack}, 32'h00000000);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clock); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbAcc(1'b1, a, d);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] want);
		wbAcc(1'b0, a, 32'h00000000);
		cmp(rd, want);
	endtask

	task automatic initWait();
		rd = 32'h00000000;
		for (int k = 0; k < 10 && rd[8] !== 1'b1; k++) wbAcc(1'b0, `DRP_OFS_MAIN, 32'h00000000);
		cmp(rd[8], 32'h00000001);
	endtask

	// Cycles until a poll starts, then waits for it to finish
	task automatic waitPoll(input int lim, output int c);
		c = 0;
		while (pollBusy !== 1'b1 && c < lim) begin
			@(posedge clock);
			c++;
		end
		for (int k = 0; pollBusy === 1'b1 && k < 300; k++) @(posedge clock);
	endtask

	task automatic chkSeen();
		cmp(i_mem.seen.size(), exp.size());
		foreach (exp[i]) cmp(i_mem.seen[i], exp[i]);
		i_mem.seen.delete();
	endtask

	task automatic pulseIn(input int w);
		@(posedge clock);
		{txAdvance, rxAdvance, frameTxDone, frameRxDone} <= 4'h1 << w;
		@(posedge clock);
		{txAdvance, rxAdvance, frameTxDone, frameRxDone} <= 4'h0;
	endtask

	task results();
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		results();
	end

	initial begin
		{rst_b, cyc, stb, we, chanBusy, slow} = 6'h00;
		{txAdvance, rxAdvance, frameTxDone, frameRxDone} = 4'h0;
		adr = 8'h00;
		wdat = 32'h00000000;
		sel = 4'hF;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		rdChk(`DRP_OFS_POLL_IVAL, 32'h00000020);
		rdChk(8'h4C, 32'h00000000);
		wr(`DRP_OFS_IMASK, 32'h00000020);
		rdChk(`DRP_OFS_IMASK, 32'h00000020);
		// 32-bit rings: rx entries 0x1000/0x1010 owned, tx entry 0x2000 free
		i_mem.put(32'h00001004, 32'h80000000);
		i_mem.put(32'h00001000, 32'h0000A000);
		i_mem.put(32'h00001014, 32'h80000000);
		wr(`DRP_OFS_STRUCT, 32'h00000100);
		wr(`DRP_OFS_INIT_RX_BASE, 32'h00001000);
		wr(`DRP_OFS_INIT_TX_BASE, 32'h00002000);
		wr(`DRP_OFS_INIT_LENS, 32'h02580003);
		wr(`DRP_OFS_MAIN, 32'h00000001);
		initWait();
		rdChk(`DRP_OFS_CUR_RX, 32'h00001000);
		rdChk(`DRP_OFS_NEXT_RX, 32'h00001010);
		rdChk(`DRP_OFS_NEXT_TX, 32'h00002010);
		rdChk(`DRP_OFS_TX_LEN, 32'h00000200);
		rdChk(`DRP_OFS_RX_LEN, 32'h00000003);
		wr(`DRP_OFS_TX_LEN, 32'h0000FFFF);
		rdChk(`DRP_OFS_TX_LEN, 32'h0000FFFF);
		wr(`DRP_OFS_POLL_IVAL, IVAL);
		wr(`DRP_OFS_MAIN, 32'h00000002);
		// Run is taken on a half-rate tick; let it land before reading
		@(posedge clock);
		wbAcc(1'b0, `DRP_OFS_MAIN, 32'h00000000);
		cmp(rd[5:4], 32'h00000003);
		waitPoll(IVAL + 20, n);
		waitPoll(IVAL + 20, n);
		cmp(n >= IVAL - 6 && n <= IVAL + 6, 32'h00000001);
		exp = '{32'h00001004, 32'h00001000, 32'h00001014, 32'h00002004, 32'h00002000,
			32'h00002004, 32'h00002000};
		chkSeen();
		rdChk(`DRP_OFS_OWN, 32'h00000003);
		rdChk(`DRP_OFS_RX_ADDRW, 32'h0000A000);
		rdChk(`DRP_OFS_RX_STAT, 32'h80000000);
		// Activity holds off an expired poll
		chanBusy <= 1'b1;
		waitPoll(IVAL + 40, n);
		cmp(n, IVAL + 40);
		chanBusy <= 1'b0;
		waitPoll(20, n);
		cmp(n < 20, 32'h00000001);
		for (int w = 0; w < 2; w++) begin
			pulseIn(w);
			waitPoll(12, n);
			cmp(n < 12, 32'h00000001);
		end
		exp = '{32'h00002004, 32'h00002000, 32'h00002004, 32'h00002000, 32'h00002004, 32'h00002000};
		chkSeen();
		// Slow memory, rx entry released, demanded poll
		slow <= 1'b1;
		pulseIn(2);
		rdChk(`DRP_OFS_CUR_RX, 32'h00001010);
		wr(`DRP_OFS_MAIN, 32'h00000008);
		waitPoll(12, n);
		cmp(n < 12, 32'h00000001);
		exp = '{32'h00001014, 32'h00001010, 32'h00001024, 32'h00002004, 32'h00002000};
		chkSeen();
		wr(`DRP_OFS_FEATURE, 32'h00000004);
		wr(`DRP_OFS_MAIN, 32'h00000008);
		waitPoll(12, n);
		exp = '{32'h00001014, 32'h00001010, 32'h00001024};
		chkSeen();
		wr(`DRP_OFS_FEATURE, 32'h00000000);
		// Stopped: no descriptor access at all
		wr(`DRP_OFS_MAIN, 32'h00000004);
		wr(`DRP_OFS_MAIN, 32'h00000008);
		waitPoll(IVAL + 20, n);
		cmp(n, IVAL + 20);
		exp.delete();
		chkSeen();
		// 16-bit rings, single rx entry, owned tx entry
		slow <= 1'b0;
		i_mem.put(32'h00003002, 32'h00008000);
		i_mem.put(32'h00004002, 32'h00008000);
		i_mem.put(32'h00004000, 32'h00005678);
		wr(`DRP_OFS_STRUCT, 32'h00000000);
		wr(`DRP_OFS_INIT_RX_BASE, 32'h00003000);
		wr(`DRP_OFS_INIT_TX_BASE, 32'h00004000);
		wr(`DRP_OFS_INIT_LENS, 32'h01000000);
		wr(`DRP_OFS_MAIN, 32'h00000001);
		initWait();
		rdChk(`DRP_OFS_TX_LEN, 32'h00000080);
		rdChk(`DRP_OFS_NEXT_TX, 32'h00004008);
		wr(`DRP_OFS_MAIN, 32'h00000002);
		waitPoll(200, n);
		exp = '{32'h00003002, 32'h00003000, 32'h00004002, 32'h00004000};
		chkSeen();
		cmp({rxOwned, txOwned}, 32'h00000003);
		rdChk(`DRP_OFS_TX_ADDRW, 32'h00005678);
		pulseIn(3);
		@(posedge clock);
		cmp(txOwned, 32'h00000000);
		results();
	end

endmodule // tb
